// *** hbd_pkg.sv ***
// shared constants and types of the host bus data phase, both ends
//
// Overview of operation
// - device drives three-bit bus clock select
// - all agents share one bus frequency
// - shared 64-bit active-low data path
// - source asserts data valid each transfer clock
// - four data words per bus clock
// - capture on alternating positive/negative strobe falls
// - four 16-bit groups, own strobe and inversion
// - inverted group is read active high
// - data owner holds bus-in-use asserted
// - bus free only after bus-in-use release
// - deferred transaction awaits later completion
// - addressed agent drives the deferral signal
// - invert group when over half bits toggle
package hbd_pkg;
  localparam int DATA_W = 64;
  localparam int GROUPS = 4;
  localparam int GROUP_W = 16;
  localparam int WORDS = 4;
  localparam int SEL_W = 3;
  localparam int INV_LIMIT = GROUP_W / 2;
  localparam int CLK_PERIOD_NS = 100;
  localparam int BUS_CLK_PERIOD_NS = 800;
  localparam int BUS_CLK_CYCLES = BUS_CLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WORD_CYCLES = BUS_CLK_CYCLES / WORDS;
  localparam logic [SEL_W-1:0] BUS_SEL_DEFAULT = 3'h1;

  typedef logic [WORDS*DATA_W-1:0] hbd_line_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [GROUPS-1:0] inv;
    logic [GROUPS-1:0] strbP;
    logic [GROUPS-1:0] strbN;
    logic valid;
    logic oe;
    logic busy;
    logic busyOe;
  } hbd_drive_t;

  localparam hbd_drive_t DRIVE_IDLE = '{
    data: 64'hFFFF_FFFF_FFFF_FFFF, inv: 4'hF, strbP: 4'hF, strbN: 4'hF,
    valid: 1'h1, oe: 1'h0, busy: 1'h0, busyOe: 1'h0};
endpackage

// *** hbd_bus_if.sv ***
// shared host bus wires with pull-up resolution of both agents' drivers
`timescale 1ns/1ps
`default_nettype none
interface hbd_bus_if;
  import hbd_pkg::*;
  logic host_bus_clk;
  hbd_drive_t cpuDrv;
  hbd_drive_t hubDrv;
  logic [SEL_W-1:0] bus_clock_select;
  logic deferred_reply_n;
  logic [DATA_W-1:0] data_n;
  logic [GROUPS-1:0] data_invert_n;
  logic [GROUPS-1:0] data_strobe_pos_n;
  logic [GROUPS-1:0] data_strobe_neg_n;
  logic data_valid_n;
  logic data_bus_in_use_n;

  // undriven lines float high through the board pull-ups
  assign data_n = cpuDrv.oe ? cpuDrv.data : (hubDrv.oe ? hubDrv.data : '1);
  assign data_invert_n = cpuDrv.oe ? cpuDrv.inv :
                         (hubDrv.oe ? hubDrv.inv : '1);
  assign data_strobe_pos_n = cpuDrv.oe ? cpuDrv.strbP :
                             (hubDrv.oe ? hubDrv.strbP : '1);
  assign data_strobe_neg_n = cpuDrv.oe ? cpuDrv.strbN :
                             (hubDrv.oe ? hubDrv.strbN : '1);
  assign data_valid_n = cpuDrv.oe ? cpuDrv.valid :
                        (hubDrv.oe ? hubDrv.valid : 1'b1);
  assign data_bus_in_use_n = !((cpuDrv.busyOe && !cpuDrv.busy) ||
                               (hubDrv.busyOe && !hubDrv.busy));

  modport cpu (
    input host_bus_clk, data_n, data_invert_n, data_strobe_pos_n,
    input data_strobe_neg_n, data_valid_n, data_bus_in_use_n,
    input deferred_reply_n,
    output cpuDrv, bus_clock_select
  );
  modport hub (
    input host_bus_clk, data_n, data_invert_n, data_strobe_pos_n,
    input data_strobe_neg_n, data_valid_n, data_bus_in_use_n,
    input bus_clock_select,
    output hubDrv, deferred_reply_n
  );
endinterface // hbd_bus_if
`default_nettype wire

// *** hbd_cpu_end.sv ***
// data-phase engine shared by both agents, and the processor end
`timescale 1ns/1ps
`default_nettype none
module hbd_data_engine #(
  parameter int WORD_CYC = hbd_pkg::WORD_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic busClkPin,
  input wire logic [hbd_pkg::DATA_W-1:0] dataPin,
  input wire logic [hbd_pkg::GROUPS-1:0] invPin,
  input wire logic [hbd_pkg::GROUPS-1:0] strbPPin,
  input wire logic [hbd_pkg::GROUPS-1:0] strbNPin,
  input wire logic validPin,
  input wire logic busyPin,
  output hbd_pkg::hbd_drive_t drv,
  input wire logic txStart,
  input wire hbd_pkg::hbd_line_t txLine,
  output logic txReady,
  output hbd_pkg::hbd_line_t rxLine,
  output logic rxValid
);
  import hbd_pkg::*;

  localparam int BUS_CYC = WORD_CYC * WORDS;
  localparam int CW = $clog2(BUS_CYC);

  // the strobe needs a high and a low half inside every word
  if (WORD_CYC < 2) begin : g_bad_word_cyc
    $error("hbd_data_engine: WORD_CYC must be at least 2");
  end

  typedef enum logic [1:0] {TX_IDLE, TX_ARM, TX_DRIVE, TX_RELEASE} hbd_tx_t;
  typedef struct packed {
    hbd_tx_t tx;
    logic [CW-1:0] cnt;
    hbd_line_t line;
    logic [DATA_W-1:0] lastWire;
    hbd_drive_t drv;
    logic txReady;
    logic bclkS1, bclkS2, bclkPrev;
    logic [DATA_W-1:0] dataS1, dataS2;
    logic [GROUPS-1:0] invS1, invS2, pS1, pS2, pPrev, nS1, nS2, nPrev;
    logic validS1, validS2, busyS1, busyS2;
    logic [GROUPS-1:0][1:0] rxCnt;
    logic [GROUPS-1:0] rxDone;
    hbd_line_t rxBuf, rxLine;
    logic rxValid;
  } hbd_eng_t;
  // idle-high lines so that no false edge or claim follows reset
  localparam hbd_eng_t ENG_RESET = '{tx: TX_IDLE, drv: DRIVE_IDLE,
    lastWire: '1, validS1: 1'b1, validS2: 1'b1, busyS1: 1'b1, busyS2: 1'b1,
    pS1: '1, pS2: '1, pPrev: '1, nS1: '1, nS2: '1, nPrev: '1, default: '0};

  hbd_eng_t s, next_s;
  logic [1:0] word;
  int sub, idx;
  logic fall, busRise;
  logic [GROUP_W-1:0] wireGrp;

  // wire value for one group: inverted when that toggles fewer lines
  function automatic logic [GROUP_W:0] encodeGroup(
    input logic [GROUP_W-1:0] d,
    input logic [GROUP_W-1:0] prevWire
  );
    logic [GROUP_W-1:0] plain;
    plain = ~d;
    if ($countones(plain ^ prevWire) > INV_LIMIT) begin
      return {1'b0, d};
    end
    return {1'b1, plain};
  endfunction

  always_comb begin
    next_s = s;
    word = '0;
    sub = 0;
    idx = 0;
    fall = 1'b0;
    wireGrp = '0;
    next_s.bclkS1 = busClkPin;
    next_s.bclkS2 = s.bclkS1;
    next_s.bclkPrev = s.bclkS2;
    next_s.dataS1 = dataPin;
    next_s.dataS2 = s.dataS1;
    next_s.invS1 = invPin;
    next_s.invS2 = s.invS1;
    next_s.pS1 = strbPPin;
    next_s.pS2 = s.pS1;
    next_s.pPrev = s.pS2;
    next_s.nS1 = strbNPin;
    next_s.nS2 = s.nS1;
    next_s.nPrev = s.nS2;
    next_s.validS1 = validPin;
    next_s.validS2 = s.validS1;
    next_s.busyS1 = busyPin;
    next_s.busyS2 = s.busyS1;
    next_s.rxValid = 1'b0;
    // transfers start on the shared bus clock, so both ends keep its rate
    busRise = s.bclkS2 && !s.bclkPrev;

    unique case (s.tx)
      TX_IDLE: begin
        if (txStart && s.txReady && s.busyS2) begin
          next_s.tx = TX_ARM;
          next_s.line = txLine;
          next_s.lastWire = '1;
          next_s.drv.busyOe = 1'b1;
          next_s.drv.busy = 1'b0;
        end
      end
      TX_ARM: begin
        if (busRise) begin
          next_s.tx = TX_DRIVE;
          next_s.cnt = '0;
        end
      end
      TX_DRIVE: begin
        word = 2'(int'(s.cnt) / WORD_CYC);
        sub = int'(s.cnt) % WORD_CYC;
        next_s.drv.oe = 1'b1;
        next_s.drv.valid = 1'b0;
        if (sub == 0) begin
          for (int g = 0; g < GROUPS; g++) begin
            idx = int'(word) * DATA_W + g * GROUP_W;
            {next_s.drv.inv[g], wireGrp} =
              encodeGroup(s.line[idx +: GROUP_W],
                          s.lastWire[g*GROUP_W +: GROUP_W]);
            next_s.drv.data[g*GROUP_W +: GROUP_W] = wireGrp;
            next_s.lastWire[g*GROUP_W +: GROUP_W] = wireGrp;
          end
        end
        // low half of each word: positive strobe for even, negative odd
        next_s.drv.strbP = (sub >= WORD_CYC / 2 && !word[0]) ? '0 : '1;
        next_s.drv.strbN = (sub >= WORD_CYC / 2 && word[0]) ? '0 : '1;
        next_s.cnt = s.cnt + 1'b1;
        if (int'(s.cnt) == BUS_CYC - 1) begin
          next_s.tx = TX_RELEASE;
        end
      end
      TX_RELEASE: begin
        next_s.drv = DRIVE_IDLE;
        next_s.tx = TX_IDLE;
      end
    endcase

    // other agent frees the bus only by releasing bus-in-use
    next_s.txReady = (next_s.tx == TX_IDLE) && s.busyS2;

    if (s.tx == TX_IDLE && s.busyS2) begin
      next_s.rxCnt = '0;
      next_s.rxDone = '0;
    end else if (s.tx == TX_IDLE && !s.validS2) begin
      for (int g = 0; g < GROUPS; g++) begin
        fall = s.rxCnt[g][0] ? (s.nPrev[g] && !s.nS2[g]) :
                               (s.pPrev[g] && !s.pS2[g]);
        if (fall && !s.rxDone[g]) begin
          idx = (int'(s.rxCnt[g]) * GROUPS + g) * GROUP_W;
          wireGrp = s.dataS2[g*GROUP_W +: GROUP_W];
          next_s.rxBuf[idx +: GROUP_W] = s.invS2[g] ? ~wireGrp : wireGrp;
          next_s.rxCnt[g] = s.rxCnt[g] + 1'b1;
          if (s.rxCnt[g] == 2'(WORDS - 1)) begin
            next_s.rxDone[g] = 1'b1;
          end
        end
      end
    end
    if (&s.rxDone) begin
      next_s.rxDone = '0;
      next_s.rxLine = s.rxBuf;
      next_s.rxValid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= ENG_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign drv = s.drv;
  assign txReady = s.txReady;
  assign rxLine = s.rxLine;
  assign rxValid = s.rxValid;
endmodule // hbd_data_engine

module hbd_cpu_end #(
  parameter logic [hbd_pkg::SEL_W-1:0] BUS_SEL = hbd_pkg::BUS_SEL_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  hbd_bus_if.cpu bus,
  input wire logic txStart,
  input wire hbd_pkg::hbd_line_t txLine,
  output logic txReady,
  output hbd_pkg::hbd_line_t rxLine,
  output logic rxValid,
  input wire logic readReq,
  output logic readDeferred,
  output logic readDone,
  output logic doneDeferred
);
  import hbd_pkg::*;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic defS1, defS2, waiting, deferred, readDone, doneDeferred;
  } hbd_cpu_t;

  hbd_cpu_t s, next_s;
  logic engRxValid;

  hbd_data_engine u_engine (
    .clk(clk),
    .rst(rst),
    .busClkPin(bus.host_bus_clk),
    .dataPin(bus.data_n),
    .invPin(bus.data_invert_n),
    .strbPPin(bus.data_strobe_pos_n),
    .strbNPin(bus.data_strobe_neg_n),
    .validPin(bus.data_valid_n),
    .busyPin(bus.data_bus_in_use_n),
    .drv(bus.cpuDrv),
    .txStart(txStart),
    .txLine(txLine),
    .txReady(txReady),
    .rxLine(rxLine),
    .rxValid(engRxValid)
  );

  always_comb begin
    next_s = s;
    next_s.sel = BUS_SEL;
    next_s.defS1 = bus.deferred_reply_n;
    next_s.defS2 = s.defS1;
    next_s.readDone = 1'b0;
    next_s.doneDeferred = 1'b0;
    if (readReq && !s.waiting) begin
      next_s.waiting = 1'b1;
    end
    // a deferral seen in the same cycle as the data still marks it
    if (s.waiting && !s.defS2) begin
      next_s.deferred = 1'b1;
    end
    if (s.waiting && engRxValid) begin
      next_s.waiting = 1'b0;
      next_s.deferred = 1'b0;
      next_s.readDone = 1'b1;
      next_s.doneDeferred = s.deferred || !s.defS2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.sel <= BUS_SEL;
      s.defS1 <= 1'b1;
      s.defS2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign bus.bus_clock_select = s.sel;
  assign rxValid = engRxValid;
  assign readDeferred = s.deferred;
  assign readDone = s.readDone;
  assign doneDeferred = s.doneDeferred;
endmodule // hbd_cpu_end
`default_nettype wire

// *** hbd_hub_end.sv ***
// chipset agent end of the host bus data phase
`timescale 1ns/1ps
`default_nettype none
module hbd_hub_end #(
  parameter logic [hbd_pkg::SEL_W-1:0] HUB_SEL = hbd_pkg::BUS_SEL_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  hbd_bus_if.hub bus,
  input wire logic txStart,
  input wire hbd_pkg::hbd_line_t txLine,
  output logic txReady,
  output hbd_pkg::hbd_line_t rxLine,
  output logic rxValid,
  input wire logic deferReq,
  output logic selMismatch
);
  import hbd_pkg::*;

  typedef struct packed {
    logic [SEL_W-1:0] selS1;
    logic [SEL_W-1:0] selS2;
    logic mismatch;
    logic deferred_reply_n_n;
  } hbd_hub_t;

  hbd_hub_t s;
  hbd_hub_t next_s;

  hbd_data_engine u_engine (
    .clk(clk),
    .rst(rst),
    .busClkPin(bus.host_bus_clk),
    .dataPin(bus.data_n),
    .invPin(bus.data_invert_n),
    .strbPPin(bus.data_strobe_pos_n),
    .strbNPin(bus.data_strobe_neg_n),
    .validPin(bus.data_valid_n),
    .busyPin(bus.data_bus_in_use_n),
    .drv(bus.hubDrv),
    .txStart(txStart),
    .txLine(txLine),
    .txReady(txReady),
    .rxLine(rxLine),
    .rxValid(rxValid)
  );

  always_comb begin
    next_s = s;
    next_s.selS1 = bus.bus_clock_select;
    next_s.selS2 = s.selS1;
    // a clock source set up for another rate would break every transfer
    next_s.mismatch = (s.selS2 != HUB_SEL);
    next_s.deferred_reply_n_n = !deferReq;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.selS1 <= HUB_SEL;
      s.selS2 <= HUB_SEL;
      s.deferred_reply_n_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign bus.deferred_reply_n = s.deferred_reply_n_n;
  assign selMismatch = s.mismatch;
endmodule // hbd_hub_end
`default_nettype wire

// *** hbd_props.sv ***
// concurrent checks on the shared host bus wires
`timescale 1ns/1ps
`default_nettype none
module hbd_props #(
  parameter logic [2:0] SEL = 3'h1
) (
  input wire logic clk,
  input wire logic rst,
  input wire hbd_pkg::hbd_drive_t cpuDrv,
  input wire hbd_pkg::hbd_drive_t hubDrv,
  input wire logic [2:0] bus_clock_select,
  input wire logic [63:0] data_n,
  input wire logic [3:0] data_invert_n,
  input wire logic [3:0] data_strobe_pos_n,
  input wire logic [3:0] data_strobe_neg_n,
  input wire logic data_valid_n,
  input wire logic data_bus_in_use_n
);
  import hbd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // inversion caps every group at half its lines toggling per transfer
  function automatic logic calm(logic [63:0] a, logic [63:0] b);
    calm = 1'b1;
    for (int g = 0; g < 4; g++) begin
      if ($countones(a[16*g+:16] ^ b[16*g+:16]) > 8) calm = 1'b0;
    end
  endfunction
  a_select_fixed: assert property (bus_clock_select == SEL)
    else $error("bus clock select moved");
  a_valid_busy: assert property (!data_valid_n |-> !data_bus_in_use_n)
    else $error("valid without bus in use");
  a_one_driver: assert property (!(cpuDrv.oe && hubDrv.oe))
    else $error("both ends drive data");
  a_eight_valid: assert property ($fell(data_valid_n) |->
    !data_valid_n [*8] ##1 data_valid_n)
    else $error("valid not eight cycles");
  a_release_busy: assert property ($rose(data_valid_n) |->
    $rose(data_bus_in_use_n))
    else $error("bus in use not released with data");
  a_strobe_walk: assert property ($fell(data_valid_n) |->
    data_strobe_pos_n == 4'hF ##1 data_strobe_pos_n == 4'h0
    ##1 data_strobe_pos_n == 4'hF && data_strobe_neg_n == 4'hF
    ##1 data_strobe_neg_n == 4'h0 ##1 data_strobe_neg_n == 4'hF
    ##1 data_strobe_pos_n == 4'h0 ##1 data_strobe_pos_n == 4'hF
    ##1 data_strobe_neg_n == 4'h0)
    else $error("strobe sequence wrong");
  a_few_toggles: assert property (!data_valid_n |->
    calm(data_n, $past(data_n)))
    else $error("group toggles more than half");
  a_cpu_claim: assert property ($rose(cpuDrv.oe) |->
    $past(cpuDrv.busyOe) && !$past(hubDrv.busyOe))
    else $error("processor drove without claim");
  a_hub_claim: assert property ($rose(hubDrv.oe) |->
    $past(hubDrv.busyOe) && !$past(cpuDrv.busyOe))
    else $error("hub drove without claim");
  c_cpu_sends: cover property ($rose(cpuDrv.oe));
  c_hub_sends: cover property ($rose(hubDrv.oe));
  c_inverted: cover property (!data_valid_n && data_invert_n != 4'hF);
endmodule // hbd_props
`default_nettype wire

// *** tb_host_bus_data_phase.sv ***
// self-checking bench: processor and chipset ends across one host bus
`timescale 1ns/1ps
`default_nettype none
module tb_host_bus_data_phase;
  import hbd_pkg::*;
  logic clk, rst, cStart, hStart, readReq, deferReq, lastDef;
  logic cReady, hReady, cRxValid, hRxValid, readDeferred, readDone;
  logic doneDeferred, selMismatch;
  hbd_line_t cLine, hLine, cRx, hRx;
  hbd_line_t toHub[$];
  hbd_line_t toCpu[$];
  int fails = 0;
  int check_count = 0;
  int vcnt = 0;
  int dones = 0;
  hbd_bus_if link ();
  hbd_cpu_end i_hbd_cpu_end (.clk(clk), .rst(rst), .bus(link),
    .txStart(cStart), .txLine(cLine), .txReady(cReady), .rxLine(cRx),
    .rxValid(cRxValid), .readReq(readReq), .readDeferred(readDeferred),
    .readDone(readDone), .doneDeferred(doneDeferred));
  hbd_hub_end i_hbd_hub_end (.clk(clk), .rst(rst), .bus(link),
    .txStart(hStart), .txLine(hLine), .txReady(hReady), .rxLine(hRx),
    .rxValid(hRxValid), .deferReq(deferReq), .selMismatch(selMismatch));
  hbd_props #(.SEL(3'h1)) i_hbd_props (.clk(clk), .rst(rst),
    .cpuDrv(link.cpuDrv), .hubDrv(link.hubDrv),
    .bus_clock_select(link.bus_clock_select), .data_n(link.data_n),
    .data_invert_n(link.data_invert_n),
    .data_strobe_pos_n(link.data_strobe_pos_n),
    .data_strobe_neg_n(link.data_strobe_neg_n),
    .data_valid_n(link.data_valid_n),
    .data_bus_in_use_n(link.data_bus_in_use_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // odd offset keeps the bus clock out of phase with clk
  initial begin
    link.host_bus_clk = 1'b0;
    #37;
    forever #400 link.host_bus_clk = ~link.host_bus_clk;
  end
  task automatic cmp(input hbd_line_t got, input hbd_line_t exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic waitHigh(ref logic s);
    int n = 0;
    while (s !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    cmp(hbd_line_t'(s), 256'h1);
  endtask
  function automatic hbd_line_t rnd();
    for (int i = 0; i < 8; i++) rnd[32*i+:32] = $urandom;
  endfunction
  // the model: one queue of expected lines per direction
  always @(negedge clk) begin
    if (hRxValid === 1'b1) begin
      cmp(hbd_line_t'(toHub.size() != 0), 256'h1);
      if (toHub.size() != 0) cmp(hRx, toHub.pop_front());
    end
    if (cRxValid === 1'b1) begin
      cmp(hbd_line_t'(toCpu.size() != 0), 256'h1);
      if (toCpu.size() != 0) cmp(cRx, toCpu.pop_front());
    end
    if (readDone === 1'b1) begin
      dones++;
      lastDef = doneDeferred;
    end
    if (link.data_valid_n === 1'b0) vcnt++;
    else if (vcnt != 0) begin
      cmp(hbd_line_t'(vcnt), 256'h8);
      vcnt = 0;
    end
  end
  task automatic send(input bit toH, input hbd_line_t l);
    if (toH) waitHigh(cReady);
    else waitHigh(hReady);
    @(posedge clk);
    if (toH) begin
      cStart <= 1'b1;
      cLine <= l;
      toHub.push_back(l);
    end else begin
      hStart <= 1'b1;
      hLine <= l;
      toCpu.push_back(l);
    end
    @(posedge clk);
    cStart <= 1'b0;
    hStart <= 1'b0;
    repeat (6) @(negedge clk);
    cmp(hbd_line_t'(toH ? hReady : cReady), 256'h0);
    // far end tries to send into a busy bus; nothing may arrive
    @(posedge clk);
    hStart <= toH;
    cStart <= !toH;
    @(posedge clk);
    hStart <= 1'b0;
    cStart <= 1'b0;
    for (int n = 0; n < 300 && toHub.size() + toCpu.size() != 0; n++) begin
      @(negedge clk);
    end
    cmp(hbd_line_t'(toHub.size() + toCpu.size()), 256'h0);
  endtask
  initial begin
    #2_000_000;
    fails++;
    conclude();
  end
  initial begin
    hbd_line_t pats[4];
    pats = '{'0, '1, {64{4'hA}}, {16{16'hFF00}}};
    void'($urandom(13));
    rst = 1'b1;
    cStart = 1'b0;
    hStart = 1'b0;
    cLine = '0;
    hLine = '0;
    readReq = 1'b0;
    deferReq = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    cmp(hbd_line_t'(link.bus_clock_select), 256'h1);
    cmp(hbd_line_t'(selMismatch), 256'h0);
    for (int i = 0; i < 16; i++) begin
      send(i[0], i < 8 ? pats[i/2] : rnd());
    end
    // select has long passed both sync stages of the hub by now
    cmp(hbd_line_t'(selMismatch), 256'h0);
    for (int d = 0; d < 2; d++) begin
      @(posedge clk);
      readReq <= 1'b1;
      deferReq <= d[0];
      @(posedge clk);
      readReq <= 1'b0;
      repeat (6) @(negedge clk);
      cmp(hbd_line_t'(readDeferred), hbd_line_t'(d));
      dones = 0;
      send(1'b0, rnd());
      repeat (3) @(negedge clk);
      cmp(hbd_line_t'({dones == 1, lastDef}), hbd_line_t'(2 + d));
      cmp(hbd_line_t'(readDeferred), 256'h0);
      @(posedge clk);
      deferReq <= 1'b0;
    end
    conclude();
  end
endmodule // tb_host_bus_data_phase
`default_nettype wire
